// ### hw/qsw_link_if.sv
// Carrier between the reference-clock control logic and the serial
// clock shifter. Words in it are quasi-static across the crossing.
interface qsw_link_if;
   // Control side to shifter
   logic [7:0] resp;
   logic       link_rst;
   // Shifter to control side
   logic [7:0] rx_byte;
   logic [2:0] bit_cnt;
   logic       clk_tog;
   logic       started;
   logic       drive_low;

   modport ctrl  (output resp, output link_rst,
                  input rx_byte, input bit_cnt, input clk_tog, input started, input drive_low);
   modport shift (input resp, input link_rst,
                  output rx_byte, output bit_cnt, output clk_tog, output started, output drive_low);
endinterface

// ### hw/qsw_pkg.sv
// Shared constants for the quad switch serial control port.
// Assumes an 8-bit frame, four channels and one reference clock domain
// plus the serial clock domain of the link.
package qsw_pkg;

   // -----------------------------------------------------------------
   // Frame layout
   // -----------------------------------------------------------------
   localparam int NCH        = 4;
   localparam int FRAME_BITS = 8;
   localparam int CNT_W      = 3;
   localparam int REQ_MSB    = 7;
   localparam int REQ_LSB    = 4;
   localparam int RW_BIT     = 3;
   localparam int PAR_MSB    = 2;
   localparam int PAR_LSB    = 0;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [NCH-1:0]        CH_RST    = 4'h0;
   localparam logic [NCH-1:0]        FAULT_RST = 4'h0;
   localparam logic [FRAME_BITS-1:0] RESP_RST  = 8'h00;
   localparam logic [CNT_W-1:0]      CNT_RST   = 3'h0;

   // -----------------------------------------------------------------
   // Synchroniser bank: {faults, started, toggle, sdi, chip select}
   // -----------------------------------------------------------------
   localparam int              ASYNC_W  = 8;
   localparam logic [7:0]      SYNC_RST = 8'h01;
   localparam int              S_CS     = 0;
   localparam int              S_SDI    = 1;
   localparam int              S_TOG    = 2;
   localparam int              S_START  = 3;
   localparam int              S_FAULT  = 4;

   typedef enum logic {FR_IDLE, FR_ACTIVE} qsw_frame_t;

endpackage

// ### hw/qsw_spi_shifter.sv
// Serial clock domain of the control port: shift in, shift out, count.
// Assumes the serial clock stands still while chip select is high.
module qsw_spi_shifter (
   // Link pins
   input  wire logic       sclk,
   input  wire logic       chip_select_n_pin,
   input  wire logic       sdi,
   // Carrier to control logic
   qsw_link_if.shift       link
);

   logic       started_q;
   logic       nstart_q;
   logic       drive_q;
   logic [7:0] sr_q;
   logic [2:0] cnt_q;
   logic       tog_q;
   wire        out_bit = started_q ? sr_q[7] : link.resp[7];

   // -----------------------------------------------------------------
   // Rising edge: launch the next bit
   // -----------------------------------------------------------------
   // Chip select high ends the frame without needing a clock edge
   always_ff @(posedge sclk or posedge chip_select_n_pin) begin
      if (chip_select_n_pin) begin
         started_q <= 1'b0;
         drive_q   <= 1'b0;
      end else begin
         started_q <= 1'b1;
         drive_q   <= ~out_bit;
      end
   end

   // -----------------------------------------------------------------
   // Falling edge: sample input, count pulses
   // -----------------------------------------------------------------
   always_ff @(negedge sclk or posedge chip_select_n_pin) begin
      if (chip_select_n_pin) begin
         nstart_q <= 1'b0;
      end else begin
         nstart_q <= 1'b1;
      end
   end

   // Not cleared by chip select: the control side reads these after the frame
   always_ff @(negedge sclk or posedge link.link_rst) begin
      if (link.link_rst) begin
         sr_q  <= qsw_pkg::RESP_RST;
         cnt_q <= qsw_pkg::CNT_RST;
         tog_q <= 1'b0;
      end else if (!nstart_q) begin
         sr_q  <= {link.resp[6:0], sdi};
         cnt_q <= 3'h1;
         tog_q <= ~tog_q;
      end else begin
         sr_q  <= {sr_q[6:0], sdi};
         cnt_q <= cnt_q + 3'h1;
      end
   end

   assign link.rx_byte   = sr_q;
   assign link.bit_cnt   = cnt_q;
   assign link.clk_tog   = tog_q;
   assign link.started   = started_q;
   assign link.drive_low = drive_q;

endmodule

// ### hw/qsw_spi_status.sv
// Serial control port of a four-channel low-side switch driver.
// Assumes the power stage reports raw channel faults as asynchronous levels
// and an external pull-up on the open-drain serial output.
module qsw_spi_status (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset,
   // Serial link
   input  wire logic       sclk,
   input  wire logic       chip_select_n_pin,
   input  wire logic       sdi,
   output logic            sdo_o,
   output logic            sdo_oe_n,
   // Power stage
   input  wire logic [3:0] channel_fault_i,
   output logic      [3:0] channel_on_o,
   // Fault indicator pin, open-drain
   output logic            fault_indicator_n_o,
   output logic            fault_indicator_n_oe_n,
   // Status
   output logic      [3:0] channel_fault_flag_o,
   output logic            frame_error_o
);

   // -----------------------------------------------------------------
   // Functions
   // -----------------------------------------------------------------
   // Parity over bits 7..3 of a frame
   function automatic logic [2:0] qsw_parity(input logic [4:0] d);
      qsw_parity = {d[4] ^ d[3] ^ d[2],
                    d[3] ^ d[2] ^ d[1],
                    d[2] ^ d[1] ^ d[0]};
   endfunction

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   qsw_link_if link ();

   logic [qsw_pkg::ASYNC_W-1:0] async_in;
   logic [qsw_pkg::ASYNC_W-1:0] s1_q;
   logic [qsw_pkg::ASYNC_W-1:0] s2_q;

   qsw_pkg::qsw_frame_t frame_q;
   qsw_pkg::qsw_frame_t frame_d;

   logic       link_rst_q;
   logic       tog_seen_q;
   logic       err_q;
   logic       err_d;
   logic [3:0] on_q;
   logic [3:0] on_d;
   logic [3:0] flag_q;
   logic [3:0] flag_d;
   logic [7:0] resp_q;
   logic [7:0] resp_live;
   logic       frame_status_bit_q;
   logic       sdo_q;
   logic       fault_pin_oe_n_q;

   // -----------------------------------------------------------------
   // Synchronisers
   // -----------------------------------------------------------------
   // Started and toggle come from the serial domain, the rest from pins
   assign async_in = {channel_fault_i, link.started, link.clk_tog, sdi, chip_select_n_pin};

   genvar gi;
   generate
      for (gi = 0; gi < qsw_pkg::ASYNC_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               s1_q[gi] <= qsw_pkg::SYNC_RST[gi];
               s2_q[gi] <= qsw_pkg::SYNC_RST[gi];
            end else begin
               s1_q[gi] <= async_in[gi];
               s2_q[gi] <= s1_q[gi];
            end
         end
      end
   endgenerate

   wire       cs_s      = s2_q[qsw_pkg::S_CS];
   wire       sdi_s     = s2_q[qsw_pkg::S_SDI];
   wire       tog_s     = s2_q[qsw_pkg::S_TOG];
   wire       started_s = s2_q[qsw_pkg::S_START];
   wire [3:0] fault_s   = s2_q[qsw_pkg::S_FAULT +: qsw_pkg::NCH];

   // -----------------------------------------------------------------
   // Serial domain
   // -----------------------------------------------------------------
   qsw_spi_shifter u_shifter (
      .sclk              (sclk),
      .chip_select_n_pin (chip_select_n_pin),
      .sdi               (sdi),
      .link              (link.shift)
   );

   // Held reset for the serial counters; released one clock after reset falls, whatever the link is doing
   always_ff @(posedge ref_clk) begin
      link_rst_q <= reset;
   end

   assign link.link_rst = link_rst_q;
   assign link.resp     = resp_q;

   // -----------------------------------------------------------------
   // Frame tracking
   // -----------------------------------------------------------------
   always_comb begin
      frame_d = frame_q;
      unique case (frame_q)
         qsw_pkg::FR_IDLE: begin
            if (!cs_s) begin
               frame_d = qsw_pkg::FR_ACTIVE;
            end
         end
         qsw_pkg::FR_ACTIVE: begin
            if (cs_s) begin
               frame_d = qsw_pkg::FR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         frame_q <= qsw_pkg::FR_IDLE;
      end else begin
         frame_q <= frame_d;
      end
   end

   // -----------------------------------------------------------------
   // End-of-frame decode
   // -----------------------------------------------------------------
   // The serial clock has stopped by the time chip select rise is seen,
   // so the received byte and pulse count are stable to read here.
   wire       frame_end   = (frame_q == qsw_pkg::FR_ACTIVE) && cs_s;
   wire       clocks_seen = tog_s ^ tog_seen_q;
   wire [7:0] rx          = link.rx_byte;
   wire       count_ok    = (link.bit_cnt == qsw_pkg::CNT_RST);
   wire [2:0] par_calc    = qsw_parity(rx[qsw_pkg::REQ_MSB:qsw_pkg::RW_BIT]);
   wire       parity_ok   = (par_calc == rx[qsw_pkg::PAR_MSB:qsw_pkg::PAR_LSB]);
   wire       frame_bad   = clocks_seen && (!count_ok || !parity_ok);
   wire       frame_valid = clocks_seen && count_ok && parity_ok;
   wire       write_req   = frame_end && frame_valid && rx[qsw_pkg::RW_BIT];
   wire       flag_clear  = frame_end && frame_valid;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tog_seen_q <= 1'b0;
      end else if (frame_end) begin
         tog_seen_q <= tog_s;
      end
   end

   // -----------------------------------------------------------------
   // Frame error flag
   // -----------------------------------------------------------------
   // Replaced at every frame end, so it stands through the next status bit
   assign err_d = frame_end ? frame_bad : err_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         err_q <= 1'b0;
      end else begin
         err_q <= err_d;
      end
   end

   // -----------------------------------------------------------------
   // Channel state
   // -----------------------------------------------------------------
   // A live fault wins over a write in the same cycle
   assign on_d = (write_req ? rx[qsw_pkg::REQ_MSB:qsw_pkg::REQ_LSB] : on_q) & ~fault_s;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         on_q <= qsw_pkg::CH_RST;
      end else begin
         on_q <= on_d;
      end
   end

   // -----------------------------------------------------------------
   // Latched channel fault flags
   // -----------------------------------------------------------------
   // Set wins over clear so a fault in the clearing cycle is kept
   assign flag_d = (flag_clear ? qsw_pkg::FAULT_RST : flag_q) | fault_s;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flag_q <= qsw_pkg::FAULT_RST;
      end else begin
         flag_q <= flag_d;
      end
   end

   // -----------------------------------------------------------------
   // Response snapshot
   // -----------------------------------------------------------------
   generate
      for (gi = 0; gi < qsw_pkg::NCH; gi++) begin : g_resp
         assign resp_live[2*gi+1] = flag_q[gi];
         assign resp_live[2*gi]   = on_q[gi];
      end
   endgenerate

   // Follows live state while idle and freezes once the frame opens
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         resp_q <= qsw_pkg::RESP_RST;
      end else if (frame_q == qsw_pkg::FR_IDLE && cs_s) begin
         resp_q <= resp_live;
      end
   end

   // -----------------------------------------------------------------
   // Status bit
   // -----------------------------------------------------------------
   // Pull low while selected, before the first rising edge, when the
   // echoed input is low or the last frame erred.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         frame_status_bit_q <= 1'b0;
      end else begin
         frame_status_bit_q <= !cs_s && !started_s && !(sdi_s && !err_q);
      end
   end

   // -----------------------------------------------------------------
   // Pins
   // -----------------------------------------------------------------
   // The data level is always low; only the enable moves
   always_ff @(posedge ref_clk) begin
      sdo_q <= 1'b0;
   end

   // Data bits must follow the serial clock within half a period, so the
   // enable selects between domains without another register stage.
   assign sdo_o    = sdo_q;
   assign sdo_oe_n = chip_select_n_pin ? 1'b1 :
                     link.started      ? ~link.drive_low : ~frame_status_bit_q;

   // Only channel faults reach the indicator
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fault_pin_oe_n_q <= 1'b1;
      end else begin
         fault_pin_oe_n_q <= ~|fault_s;
      end
   end

   assign fault_indicator_n_o    = sdo_q;
   assign fault_indicator_n_oe_n = fault_pin_oe_n_q;
   assign channel_on_o           = on_q;
   assign channel_fault_flag_o   = flag_q;
   assign frame_error_o          = err_q;

endmodule

// ### tb/qsw_spi_ctrl_model.sv
// Serial controller model: framed transfers, clock still between frames.
// Assumes the caller resolves the open-drain line with its pull-up.
module qsw_spi_ctrl_model (
   // Link pins
   output logic      sclk,
   output logic      chip_select_n_pin,
   output logic      sdi,
   input  wire logic sdo_line
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sclk = 1'b0;
      chip_select_n_pin = 1'b1;
      sdi = 1'b0;
   end

   // Sends the low nbits of tx MSB first; a chain sends 16 bits at once
   task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx, output logic stat);
      rx = 16'h0000;
      #7 chip_select_n_pin = 1'b0;
      sdi = 1'b1;
      #200 stat = sdo_line;
      for (int i = nbits - 1; i >= 0; i--) begin
         #8 sdi = tx[i];
         #8 sclk = 1'b1;
         #16 rx = {rx[14:0], sdo_line};
         sclk = 1'b0;
      end
      #200 chip_select_n_pin = 1'b1;
      // A released data line must not keep its last value
      sdi = ~sdi;
      #400;
   endtask
endmodule

// ### tb/qsw_spi_status_properties.sv
// Checker for the quad switch serial port, top-level ports only.
// Assumes the serial clock stands still while chip select is high.
module qsw_spi_status_properties (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       reset,
   // Serial link
   input wire logic       sclk,
   input wire logic       chip_select_n_pin,
   input wire logic       sdi,
   input wire logic       sdo_o,
   input wire logic       sdo_oe_n,
   // Power stage and status
   input wire logic [3:0] channel_fault_i,
   input wire logic [3:0] channel_on_o,
   input wire logic       fault_indicator_n_o,
   input wire logic       fault_indicator_n_oe_n,
   input wire logic [3:0] channel_fault_flag_o,
   input wire logic       frame_error_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       rise_seen_q;
   logic [2:0] quiet_q;
   logic [2:0] cs_low_q;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   // First serial rise ends the status interval; deselect clears it
   always_ff @(posedge sclk or posedge chip_select_n_pin) begin
      if (chip_select_n_pin) rise_seen_q <= 1'b0;
      else rise_seen_q <= 1'b1;
   end

   // Saturating counts keep the helpers small
   always_ff @(posedge ref_clk) begin
      if (reset || channel_fault_i != 4'h0) quiet_q <= 3'h0;
      else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
      if (reset || chip_select_n_pin) cs_low_q <= 3'h0;
      else if (cs_low_q != 3'h7) cs_low_q <= cs_low_q + 3'h1;
   end

   a_sdo_idle_release: assert property (chip_select_n_pin |-> sdo_oe_n)
      else $error("serial output driven while deselected");
   a_sdo_low_only: assert property (!sdo_oe_n |-> sdo_o == 1'b0)
      else $error("serial output drives high");
   a_fault_pin_quiet: assert property (quiet_q >= 3'h4 |-> fault_indicator_n_oe_n)
      else $error("fault indicator pulled without a fault");
   a_fault_sets_flag: assert property ($stable(channel_fault_i) [*4]
      |-> (channel_fault_flag_o & channel_fault_i) == channel_fault_i)
      else $error("fault flag not set");
   a_fault_forces_off: assert property ($stable(channel_fault_i) [*4]
      |-> (channel_on_o & channel_fault_i) == 4'h0)
      else $error("faulted channel left on");
   a_on_valid_only: assert property ((channel_on_o & ~$past(channel_on_o)) != 4'h0
      |-> chip_select_n_pin && !frame_error_o)
      else $error("channel turned on without a valid frame");
   a_flag_clear_valid: assert property (($past(channel_fault_flag_o) & ~channel_fault_flag_o) != 4'h0
      |-> chip_select_n_pin && !frame_error_o)
      else $error("fault flag cleared without a valid frame");
   a_err_at_end: assert property ($changed(frame_error_o) |-> chip_select_n_pin)
      else $error("frame error changed inside a frame");
   a_status_bit: assert property (cs_low_q >= 3'h4 && !rise_seen_q && $stable(sdi)
      && $past(sdi, 2) == sdi && $past(sdi, 3) == sdi
      |-> sdo_oe_n == (sdi && !frame_error_o))
      else $error("status bit wrong");
endmodule

bind qsw_spi_status qsw_spi_status_properties u_qsw_spi_status_properties (
   .ref_clk(ref_clk), .reset(reset), .sclk(sclk), .chip_select_n_pin(chip_select_n_pin),
   .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .channel_fault_i(channel_fault_i),
   .channel_on_o(channel_on_o), .fault_indicator_n_o(fault_indicator_n_o),
   .fault_indicator_n_oe_n(fault_indicator_n_oe_n), .channel_fault_flag_o(channel_fault_flag_o),
   .frame_error_o(frame_error_o));

// ### tb/tb_top.sv
// Self-checking bench for the quad switch serial control port.
// Assumes the controller model in its own file and the bound checker.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {logic [3:0] req; logic rw; logic [3:0] on;} qsw_row_t;

   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  channel_fault_i = 4'h0;
   wire         sclk;
   wire         chip_select_n_pin;
   wire         sdi;
   logic        sdo_o;
   logic        sdo_oe_n;
   logic [3:0]  channel_on_o;
   logic        fault_indicator_n_o;
   logic        fault_indicator_n_oe_n;
   logic [3:0]  channel_fault_flag_o;
   logic        frame_error_o;
   logic [15:0] rx;
   logic        stat;
   logic [3:0]  prev = 4'h0;
   int          n_errors = 0;
   int          n_tests = 0;
   int          odd [2] = '{9, 7};
   qsw_row_t    rows [4] = '{'{4'ha, 1'b1, 4'ha}, '{4'h6, 1'b0, 4'ha},
                             '{4'hf, 1'b1, 4'hf}, '{4'h0, 1'b1, 4'h0}};
   // Pull-up on the open-drain serial output
   wire         sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

   always #20 ref_clk = ~ref_clk;

   qsw_spi_status u_qsw_spi_status (
      .ref_clk(ref_clk), .reset(reset), .sclk(sclk), .chip_select_n_pin(chip_select_n_pin),
      .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .channel_fault_i(channel_fault_i),
      .channel_on_o(channel_on_o), .fault_indicator_n_o(fault_indicator_n_o),
      .fault_indicator_n_oe_n(fault_indicator_n_oe_n), .channel_fault_flag_o(channel_fault_flag_o),
      .frame_error_o(frame_error_o));

   qsw_spi_ctrl_model u_qsw_spi_ctrl_model (
      .sclk(sclk), .chip_select_n_pin(chip_select_n_pin), .sdi(sdi), .sdo_line(sdo_line));

   function automatic logic [7:0] frame(input logic [3:0] r, input logic w);
      return {r, w, r[3] ^ r[2] ^ r[1], r[2] ^ r[1] ^ r[0], r[1] ^ r[0] ^ w};
   endfunction

   function automatic logic [15:0] resp(input logic [3:0] f, input logic [3:0] s);
      return {8'h00, f[3], s[3], f[2], s[2], f[1], s[1], f[0], s[0]};
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic xfer(input int n, input logic [15:0] tx);
      u_qsw_spi_ctrl_model.xfer(n, tx, rx, stat);
      @(posedge ref_clk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // An 8-bit frame takes about 27 cycles; the whole run well under 2000
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      end_sim();
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk("reset outputs", 16'h0000, 16'({channel_on_o, channel_fault_flag_o, frame_error_o}));
      $display("reset test done");
      foreach (rows[i]) begin
         xfer(8, 16'(frame(rows[i].req, rows[i].rw)));
         chk("channel on", 16'(rows[i].on), 16'(channel_on_o));
         chk("response", resp(4'h0, prev), rx);
         chk("status ok", 16'h0001, 16'(stat));
         prev = rows[i].on;
      end
      $display("table test done");
      xfer(8, 16'(frame(4'hf, 1'b1) ^ 8'h01));
      chk("parity error", 16'h0001, 16'(frame_error_o));
      chk("parity no change", 16'h0000, 16'(channel_on_o));
      xfer(8, 16'(frame(4'h5, 1'b1)));
      chk("status after error", 16'h0000, 16'(stat));
      chk("error cleared", 16'h0000, 16'(frame_error_o));
      $display("parity test done");
      foreach (odd[i]) begin
         xfer(odd[i], 16'(frame(4'ha, 1'b1)));
         chk("count error", 16'h0001, 16'(frame_error_o));
         chk("count no decode", 16'h0005, 16'(channel_on_o));
      end
      xfer(16, {8'h3c, frame(4'h3, 1'b1)});
      chk("status after count", 16'h0000, 16'(stat));
      chk("chain response", {8'(resp(4'h0, 4'h5)), 8'h3c}, rx);
      chk("chain decode", 16'h0003, 16'(channel_on_o));
      $display("count and chain test done");
      channel_fault_i <= 4'h2;
      repeat (6) @(posedge ref_clk);
      channel_fault_i <= 4'h0;
      repeat (6) @(posedge ref_clk);
      chk("fault flag", 16'h0002, 16'(channel_fault_flag_o));
      chk("fault forces off", 16'h0001, 16'(channel_on_o));
      xfer(8, 16'(frame(4'h0, 1'b1) ^ 8'h02));
      chk("flag kept", 16'h0002, 16'(channel_fault_flag_o));
      chk("pin not pulled", 16'h0001, 16'(fault_indicator_n_oe_n));
      xfer(8, 16'(frame(4'h0, 1'b0)));
      chk("fault response", resp(4'h2, 4'h1), rx);
      chk("flag cleared", 16'h0000, 16'(channel_fault_flag_o));
      xfer(8, 16'(frame(4'h3, 1'b1)));
      chk("clean response", resp(4'h0, 4'h1), rx);
      chk("rewrite on", 16'h0003, 16'(channel_on_o));
      chk("sdo level low", 16'h0000, 16'(sdo_o));
      chk("fault pin level low", 16'h0000, 16'(fault_indicator_n_o));
      $display("fault test done");
      end_sim();
   end
endmodule
